// ### logic/rename_stall_hazard_logic.sv
// Rename stage hazard logic: read port arbitration, partial register folds,
// bypass latency between execution domains.
// Assumes the front end holds a group until taken and writebacks carry tags.
`timescale 1ns/1ps
module rename_stall_hazard_logic
   import rename_hazard_pkg::*;
(
   input wire logic clock, // Core clock, 250 MHz
   input wire logic rst, // Asynchronous reset, active high
   input wire logic mode64, // 64-bit mode enables quadword access
   input wire logic group_valid, // Front end offers a group
   input wire uop_t [SLOTS-1:0] group, // Offered micro-ops, oldest in slot 0
   output logic group_ready, // Group taken when valid and ready
   input wire wb_t [WB_PORTS-1:0] wb, // Writebacks into the reorder buffer
   output rs_uop_t [SLOTS-1:0] rs_out, // Renamed micro-ops to the stations
   output rob_read_t [READ_PORTS-1:0] rob_rd, // Reorder buffer read port requests
   output logic read_port_stall_event, // Pulse: stall for read ports
   output logic merge_stall_event, // Pulse: stall for a register fold
   output logic [COUNT_W-1:0] read_port_stall_count // Read port stalls so far
);

   reg_state_t [REGS-1:0] table_state;
   uop_t [SLOTS-1:0] held;
   uop_t [SLOTS-1:0] next_held;
   logic next_group_ready;
   rs_uop_t [SLOTS-1:0] next_rs_out;
   rob_read_t [READ_PORTS-1:0] next_rob_rd;
   logic next_read_port_stall_event;
   logic next_merge_stall_event;
   logic [COUNT_W-1:0] next_read_port_stall_count;
   wr_t [SLOTS-1:0] table_wr;
   logic merge_valid;
   logic [REG_W-1:0] merge_reg;

   // Producer state of every architectural register
   reg_state_table u_table (
      .clock(clock),
      .rst(rst),
      .wr(table_wr),
      .merge_valid(merge_valid),
      .merge_reg(merge_reg),
      .wb(wb),
      .state(table_state)
   );

   // Base latency of a micro-op by class
   function automatic logic [LAT_W-1:0] base_latency(input op_t op);
      logic [LAT_W-1:0] lat;
      lat = LAT_DEFAULT;
      if (op == OP_PACKED_SINGLE_ADD) begin
         lat = LAT_PACKED_SINGLE_ADD;
      end else if (op == OP_PACKED_INTEGER_AND) begin
         lat = LAT_PACKED_INTEGER_AND;
      end else if (op == OP_INT_LOAD) begin
         lat = LAT_INT_LOAD;
      end else if (op == OP_FP_LOAD) begin
         lat = LAT_INT_LOAD + LAT_FP_LOAD_EXTRA;
      end
      base_latency = lat;
   endfunction : base_latency

   // Rename of the held group, oldest first, stopping at the first stall
   always_comb begin
      reg_state_t [REGS-1:0] ls;
      src_t [SRCS-1:0] srcs;
      rs_uop_t ru;
      reg_state_t st;
      logic blocked;
      logic ok;
      logic fold;
      logic bypass;
      logic hit;
      logic [REG_W-1:0] fold_reg;
      int used;
      int t_used;
      logic [REG_W-1:0] port_reg [READ_PORTS];
      logic [REG_W-1:0] t_reg [READ_PORTS];
      logic [TAG_W-1:0] t_tag [READ_PORTS];
      logic [PORT_W-1:0] port;
      width_t dst_w;
      logic any_left;

      ls = table_state;
      blocked = 1'b0;
      used = 0;
      for (int p = 0; p < READ_PORTS; p++) begin
         port_reg[p] = '0;
         t_reg[p] = '0;
         t_tag[p] = '0;
      end
      srcs = '0;
      ru = '0;
      st = '0;
      ok = 1'b0;
      fold = 1'b0;
      bypass = 1'b0;
      hit = 1'b0;
      fold_reg = '0;
      t_used = 0;
      port = '0;
      dst_w = W_BYTE_LO;
      any_left = 1'b0;
      next_held = held;
      next_rs_out = '0;
      next_rob_rd = '0;
      table_wr = '0;
      merge_valid = 1'b0;
      merge_reg = '0;
      next_read_port_stall_event = 1'b0;
      next_merge_stall_event = 1'b0;
      next_read_port_stall_count = read_port_stall_count;

      for (int i = 0; i < SLOTS; i++) begin
         if (held[i].valid && !blocked) begin
            dst_w = eff_width(held[i].dst_width, mode64);
            srcs[0] = held[i].src[0];
            srcs[1] = held[i].src[1];
            srcs[0].width = eff_width(held[i].src[0].width, mode64);
            srcs[1].width = eff_width(held[i].src[1].width, mode64);
            // Partial writes also read the old destination
            srcs[SRC_OLD_DST].used = held[i].dst_used &&
                                     !full_write(dst_w, held[i].zero_ext);
            srcs[SRC_OLD_DST].regno = held[i].dst_reg;
            srcs[SRC_OLD_DST].width = dst_w;
            ru = '0;
            ru.valid = 1'b1;
            ru.op = held[i].op;
            ru.dom = held[i].dom;
            ru.tag = held[i].tag;
            ok = 1'b1;
            fold = 1'b0;
            bypass = 1'b0;
            fold_reg = '0;
            t_used = used;
            for (int p = 0; p < READ_PORTS; p++) begin
               t_reg[p] = port_reg[p];
               t_tag[p] = next_rob_rd[p].tag;
            end
            for (int s = 0; s < SRCS; s++) begin
               if (srcs[s].used) begin
                  st = ls[srcs[s].regno];
                  ru.src[s].used = 1'b1;
                  ru.src[s].tag = st.tag;
                  if (s != SRC_OLD_DST && needs_merge(st.pieces, srcs[s].width)) begin
                     fold = 1'b1;
                     fold_reg = srcs[s].regno;
                  end
                  if (crosses(st.dom, held[i].dom)) begin
                     bypass = 1'b1;
                  end
                  if (!st.in_flight) begin
                     // Written back: share a granted port or take a new one
                     hit = 1'b0;
                     port = '0;
                     for (int p = 0; p < READ_PORTS; p++) begin
                        if (p < t_used && t_reg[p] == srcs[s].regno && !hit) begin
                           hit = 1'b1;
                           port = PORT_W'(p);
                        end
                     end
                     if (!hit) begin
                        if (t_used >= READ_PORTS) begin
                           ok = 1'b0;
                        end else begin
                           port = PORT_W'(t_used);
                           t_reg[t_used] = srcs[s].regno;
                           t_tag[t_used] = st.tag;
                           t_used = t_used + 1;
                        end
                     end
                     ru.src[s].from_rob = 1'b1;
                     ru.src[s].port = port;
                  end else begin
                     ru.src[s].from_rob = 1'b0;
                  end
               end
            end
            if (fold) begin
               // Fold the pieces this cycle, retry next cycle
               blocked = 1'b1;
               merge_valid = 1'b1;
               merge_reg = fold_reg;
               next_merge_stall_event = 1'b1;
            end else if (!ok) begin
               blocked = 1'b1;
               next_read_port_stall_event = 1'b1;
               next_read_port_stall_count = read_port_stall_count + COUNT_STEP;
            end else begin
               // Commit ports, output and destination state
               used = t_used;
               for (int p = 0; p < READ_PORTS; p++) begin
                  port_reg[p] = t_reg[p];
                  next_rob_rd[p].tag = t_tag[p];
                  next_rob_rd[p].valid = p < t_used;
               end
               ru.latency = base_latency(held[i].op) + (bypass ? LAT_BYPASS : '0);
               next_rs_out[i] = ru;
               next_held[i].valid = 1'b0;
               if (held[i].dst_used) begin
                  table_wr[i].valid = 1'b1;
                  table_wr[i].regno = held[i].dst_reg;
                  table_wr[i].tag = held[i].tag;
                  table_wr[i].dom = held[i].dom;
                  table_wr[i].width = dst_w;
                  table_wr[i].zero_ext = held[i].zero_ext;
                  ls[held[i].dst_reg].in_flight = 1'b1;
                  ls[held[i].dst_reg].tag = held[i].tag;
                  ls[held[i].dst_reg].dom = held[i].dom;
                  ls[held[i].dst_reg].pieces = next_pieces(ls[held[i].dst_reg].pieces,
                                                           dst_w, held[i].zero_ext);
               end
            end
         end
      end

      // Take a new group only when the held one is empty
      any_left = 1'b0;
      for (int i = 0; i < SLOTS; i++) begin
         any_left = any_left || next_held[i].valid;
      end
      if (group_ready && group_valid) begin
         next_held = group;
         any_left = 1'b0;
         for (int i = 0; i < SLOTS; i++) begin
            any_left = any_left || group[i].valid;
         end
      end
      next_group_ready = !any_left;
   end

   // Rename stage registers
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         held <= '0;
         group_ready <= 1'b1;
         rs_out <= '0;
         rob_rd <= '0;
         read_port_stall_event <= 1'b0;
         merge_stall_event <= 1'b0;
         read_port_stall_count <= '0;
      end else begin
         held <= next_held;
         group_ready <= next_group_ready;
         rs_out <= next_rs_out;
         rob_rd <= next_rob_rd;
         read_port_stall_event <= next_read_port_stall_event;
         merge_stall_event <= next_merge_stall_event;
         read_port_stall_count <= next_read_port_stall_count;
      end
   end

endmodule : rename_stall_hazard_logic

// ### logic/rename_hazard_pkg.sv
// Shared types, field layouts and constants of the rename hazard logic.
// Assumes one core clock; the front end and the scheduler share these types.
package rename_hazard_pkg;

   localparam int SLOTS = 4; // Micro-ops renamed per group
   localparam int OPERANDS = 2; // Explicit source operands per micro-op
   localparam int SRCS = 3; // Operands plus the old destination value
   localparam int SRC_OLD_DST = 2; // Index of the old destination source
   localparam int READ_PORTS = 3; // Reorder buffer read ports, below SLOTS*OPERANDS
   localparam int REGS = 16; // Architectural registers tracked
   localparam int REG_W = 4;
   localparam int TAG_W = 6;
   localparam int PORT_W = 2;
   localparam int LAT_W = 3;
   localparam int WB_PORTS = 2;
   localparam int COUNT_W = 16;

   // Result latencies in core cycles
   localparam logic [LAT_W-1:0] LAT_PACKED_SINGLE_ADD = 3'h3;
   localparam logic [LAT_W-1:0] LAT_PACKED_INTEGER_AND = 3'h1;
   localparam logic [LAT_W-1:0] LAT_INT_LOAD = 3'h3;
   localparam logic [LAT_W-1:0] LAT_FP_LOAD_EXTRA = 3'h1;
   localparam logic [LAT_W-1:0] LAT_DEFAULT = 3'h1;
   localparam logic [LAT_W-1:0] LAT_BYPASS = 3'h1;
   localparam logic [COUNT_W-1:0] COUNT_STEP = 16'h0001;

   typedef enum logic [2:0] {
      W_BYTE_LO = 3'b000,
      W_BYTE_HI = 3'b001,
      W_WORD = 3'b010,
      W_DWORD = 3'b011,
      W_QWORD = 3'b100
   } width_t;

   typedef enum logic [1:0] {
      DOM_GPR = 2'b00,
      DOM_X87 = 2'b01,
      DOM_VEC_FP = 2'b10,
      DOM_VEC_INT = 2'b11
   } dom_t;

   typedef enum logic [2:0] {
      OP_OTHER = 3'b000,
      OP_PACKED_SINGLE_ADD = 3'b001,
      OP_PACKED_INTEGER_AND = 3'b010,
      OP_INT_LOAD = 3'b011,
      OP_FP_LOAD = 3'b100
   } op_t;

   // Pieces of a register written separately since its last full write
   typedef struct packed {
      logic low_byte;
      logic high_byte;
      logic word;
   } pieces_t;

   typedef struct packed {
      logic in_flight; // Producer not yet written back
      logic [TAG_W-1:0] tag; // Reorder buffer entry of the last producer
      dom_t dom; // Execution domain of the last producer
      pieces_t pieces;
   } reg_state_t;

   typedef struct packed {
      logic used;
      logic [REG_W-1:0] regno;
      width_t width;
   } src_t;

   typedef struct packed {
      logic valid;
      op_t op;
      dom_t dom;
      logic dst_used;
      logic [REG_W-1:0] dst_reg;
      width_t dst_width;
      logic zero_ext; // Zero-extending move into the destination
      logic [TAG_W-1:0] tag;
      src_t [OPERANDS-1:0] src;
   } uop_t;

   typedef struct packed {
      logic used;
      logic from_rob; // Read through a reorder buffer port
      logic [PORT_W-1:0] port;
      logic [TAG_W-1:0] tag; // Producer to capture when in flight
   } rs_src_t;

   typedef struct packed {
      logic valid;
      op_t op;
      dom_t dom;
      logic [TAG_W-1:0] tag;
      logic [LAT_W-1:0] latency;
      rs_src_t [SRCS-1:0] src;
   } rs_uop_t;

   typedef struct packed {
      logic valid;
      logic [REG_W-1:0] regno;
      logic [TAG_W-1:0] tag;
      dom_t dom;
      width_t width;
      logic zero_ext;
   } wr_t;

   typedef struct packed {
      logic valid;
      logic [REG_W-1:0] regno;
      logic [TAG_W-1:0] tag;
   } wb_t;

   typedef struct packed {
      logic valid;
      logic [TAG_W-1:0] tag;
   } rob_read_t;

   // Quadword access exists only in 64-bit mode
   function automatic width_t eff_width(input width_t w, input logic mode64);
      eff_width = (w == W_QWORD && !mode64) ? W_DWORD : w;
   endfunction : eff_width

   // Double-word, quadword and zero-extending writes replace the whole register
   function automatic logic full_write(input width_t w, input logic zext);
      full_write = zext || w == W_DWORD || w == W_QWORD;
   endfunction : full_write

   function automatic pieces_t next_pieces(input pieces_t p, input width_t w,
                                           input logic zext);
      pieces_t n;
      n = p;
      if (full_write(w, zext)) begin
         n = '0;
      end else if (w == W_WORD) begin
         n = '{low_byte: 1'b0, high_byte: 1'b0, word: 1'b1};
      end else if (w == W_BYTE_HI) begin
         n.high_byte = 1'b1;
      end else begin
         n.low_byte = 1'b1;
      end
      next_pieces = n;
   endfunction : next_pieces

   // A read wider than a separately written piece must wait for a fold
   function automatic logic needs_merge(input pieces_t p, input width_t w);
      if (w == W_WORD) begin
         needs_merge = p.low_byte || p.high_byte;
      end else if (w == W_DWORD || w == W_QWORD) begin
         needs_merge = p.low_byte || p.high_byte || p.word;
      end else begin
         needs_merge = 1'b0;
      end
   endfunction : needs_merge

   // Crossing between two different domains other than DOM_GPR costs a bypass cycle
   function automatic logic crosses(input dom_t a, input dom_t b);
      crosses = a != b && a != DOM_GPR && b != DOM_GPR;
   endfunction : crosses

endpackage : rename_hazard_pkg

// ### logic/reg_state_table.sv
// Per-register producer state: in flight or written back, domain, pieces.
// Assumes writes arrive in program order and writebacks carry producer tags.
`timescale 1ns/1ps
module reg_state_table
   import rename_hazard_pkg::*;
(
   input wire logic clock, // Core clock
   input wire logic rst, // Asynchronous reset
   input wire wr_t [SLOTS-1:0] wr, // Renamed destination writes, oldest first
   input wire logic merge_valid, // Fold the pieces of one register
   input wire logic [REG_W-1:0] merge_reg, // Register to fold
   input wire wb_t [WB_PORTS-1:0] wb, // Results written back to the reorder buffer
   output reg_state_t [REGS-1:0] state // Registered state of every register
);

   genvar e;
   generate
      for (e = 0; e < REGS; e++) begin : g_entry
         reg_state_t next_entry;

         // Writeback first, then renames, so a new producer wins
         always_comb begin
            next_entry = state[e];
            for (int w = 0; w < WB_PORTS; w++) begin
               if (wb[w].valid && wb[w].regno == REG_W'(e) && wb[w].tag == state[e].tag) begin
                  next_entry.in_flight = 1'b0;
               end
            end
            for (int s = 0; s < SLOTS; s++) begin
               if (wr[s].valid && wr[s].regno == REG_W'(e)) begin
                  next_entry.in_flight = 1'b1;
                  next_entry.tag = wr[s].tag;
                  next_entry.dom = wr[s].dom;
                  next_entry.pieces = next_pieces(next_entry.pieces, wr[s].width,
                                                  wr[s].zero_ext);
               end
            end
            if (merge_valid && merge_reg == REG_W'(e)) begin
               next_entry.pieces = '0;
            end
         end

         // Entry register
         always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
               state[e] <= '0;
            end else begin
               state[e] <= next_entry;
            end
         end
      end
   endgenerate

endmodule : reg_state_table

// ### testbench/rename_hazard_checker.sv
// Port checker of the rename hazard logic: order, ports, stalls, latency.
// Assumes it is bound into rename_stall_hazard_logic.
`timescale 1ns/1ps
module rename_hazard_checker
   import rename_hazard_pkg::*;
(
   input wire logic clock, // Core clock
   input wire logic rst, // Asynchronous reset
   input wire logic group_valid, // Offer
   input wire uop_t [SLOTS-1:0] group, // Offered group
   input wire logic group_ready, // Take
   input wire rs_uop_t [SLOTS-1:0] rs_out, // Renamed slots
   input wire rob_read_t [READ_PORTS-1:0] rob_rd, // Port requests
   input wire logic read_port_stall_event, // Port stall
   input wire logic merge_stall_event, // Fold stall
   input wire logic [COUNT_W-1:0] read_port_stall_count // Stall count
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (rst);

   // Take and rename sequencing
   a_take_drops_ready: assert property (group_valid && group_ready |=> !group_ready)
      else $error("ready stayed high after a take");
   a_oldest_renames: assert property (group_valid && group_ready && group[0].valid
      |-> ##[2:3] rs_out[0].valid)
      else $error("oldest slot not renamed in time");
   a_out_after_take: assert property (rs_out[0].valid || rs_out[3].valid |-> !$past(group_ready))
      else $error("slot out without a held group");
   a_port_stall_hold: assert property (read_port_stall_event |-> !group_ready)
      else $error("ready high during a port stall");
   a_fold_stall_hold: assert property (merge_stall_event |-> !group_ready)
      else $error("ready high during a fold");
   // Stall event counting
   a_count_step: assert property ($changed(read_port_stall_count)
      |-> read_port_stall_count == $past(read_port_stall_count) + 16'h0001)
      else $error("stall count jumped");
   a_event_counted: assert property (read_port_stall_event
      |-> ##[0:1] $changed(read_port_stall_count))
      else $error("stall event not counted");
   // Port grants
   a_port_granted: assert property (rs_out[0].valid && rs_out[0].src[0].used
      && rs_out[0].src[0].from_rob |-> rob_rd[rs_out[0].src[0].port].valid)
      else $error("read from a port not granted");
   a_ports_low_first: assert property (rob_rd[2].valid |-> rob_rd[1].valid && rob_rd[0].valid)
      else $error("ports not allocated from zero");

   // Latency floors per slot, one bypass cycle at most on top
   for (genvar s = 0; s < SLOTS; s++) begin : g_lat
      property p_lat(op_t o, logic [LAT_W-1:0] lo);
         rs_out[s].valid && rs_out[s].op == o |-> rs_out[s].latency inside {lo, lo + 3'h1};
      endproperty
      a_lat_single_add: assert property (p_lat(OP_PACKED_SINGLE_ADD, 3'h3))
         else $error("packed single add latency off");
      a_lat_integer_and: assert property (p_lat(OP_PACKED_INTEGER_AND, 3'h1))
         else $error("packed integer and latency off");
   end

   c_port_stall: cover property (read_port_stall_event);
   c_fold_stall: cover property (merge_stall_event);
   c_bypass: cover property (rs_out[1].valid && rs_out[1].latency == 3'h2);
endmodule : rename_hazard_checker

// ### testbench/front_end_model.sv
// Front end and writeback stand-in: offers groups, reports writebacks.
// Assumes its outputs change only at the falling clock edge.
`timescale 1ns/1ps
module front_end_model
   import rename_hazard_pkg::*;
(
   input wire logic clock, // Core clock
   input wire logic group_ready, // Design takes a group
   output logic group_valid, // Offer
   output uop_t [SLOTS-1:0] group, // Offered group
   output wb_t [WB_PORTS-1:0] wb // Writebacks
);
   initial begin
      group_valid = 1'b0;
      group = '0;
      wb = '0;
   end

   // Holds a group until taken or for at most 51 cycles, then scrambles the idle lines
   task automatic offer(input uop_t [SLOTS-1:0] g);
      int n;
      n = 0;
      @(negedge clock);
      group_valid = 1'b1;
      group = g;
      while (!group_ready && n < 50) begin
         @(negedge clock);
         n++;
      end
      @(negedge clock);
      group_valid = 1'b0;
      group = ~g;
   endtask : offer

   // One writeback on port p for one cycle
   task automatic wback(input int p, input logic [REG_W-1:0] r, input logic [TAG_W-1:0] t);
      @(negedge clock);
      wb[p] = '{valid: 1'b1, regno: r, tag: t};
      @(negedge clock);
      wb[p] = '{valid: 1'b0, regno: ~r, tag: ~t};
   endtask : wback
endmodule : front_end_model

// ### testbench/tb_top.sv
// Testbench top: read port stalls, capture, domain latency, register folds.
// Assumes the front end model drives the group and writeback inputs.
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_total++; \
   $display("ERROR %0t mismatch at line %0d", $time, `__LINE__); end end
module tb_top
   import rename_hazard_pkg::*;
;
   logic clock, rst, mode64, group_valid, group_ready, port_ev, merge_ev;
   uop_t [SLOTS-1:0] group;
   wb_t [WB_PORTS-1:0] wb;
   rs_uop_t [SLOTS-1:0] rs_out;
   rob_read_t [READ_PORTS-1:0] rob_rd;
   logic [COUNT_W-1:0] stall_cnt;
   int err_total, n_tests, cycles, ps, ms;
   rs_uop_t got [SLOTS];
   int at [SLOTS];
   rob_read_t [READ_PORTS-1:0] rob0;

   rename_stall_hazard_logic dut_u (.clock, .rst, .mode64, .group_valid, .group,
      .group_ready, .wb, .rs_out, .rob_rd, .read_port_stall_event(port_ev),
      .merge_stall_event(merge_ev), .read_port_stall_count(stall_cnt));
   front_end_model fe_u (.clock, .group_ready, .group_valid, .group, .wb);

   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   // Cuts a hang short
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         err_total++;
         print_verdict();
      end
   end

   // One valid micro-op; destination register 0 means none
   function automatic uop_t mk(op_t op, dom_t d, logic [3:0] dr, width_t dw, logic zx,
                               logic [5:0] t, logic [4:0] a, logic [4:0] b, width_t sw);
      mk = '{1'b1, op, d, dr != 4'h0, dr, dw, zx, t,
             '{'{b[4], b[3:0], sw}, '{a[4], a[3:0], sw}}};
   endfunction : mk

   function automatic uop_t rd(logic [5:0] t, logic [4:0] a, logic [4:0] b, width_t sw);
      rd = mk(OP_OTHER, DOM_GPR, 4'h0, W_DWORD, 1'b0, t, a, b, sw);
   endfunction : rd

   function automatic uop_t wr(logic [5:0] t, logic [3:0] dr, width_t dw, logic zx);
      wr = mk(OP_OTHER, DOM_GPR, dr, dw, zx, t, 5'h00, 5'h00, W_DWORD);
   endfunction : wr

   // Offers a group and gathers slots, output cycles and stall pulses
   task automatic run(input uop_t [SLOTS-1:0] g);
      int i;
      ps = 0;
      ms = 0;
      rob0 = '0;
      for (i = 0; i < SLOTS; i++) begin
         got[i] = '0;
         at[i] = -1;
      end
      fe_u.offer(g);
      for (i = 0; i < 10; i++) begin
         @(negedge clock);
         ps += int'(port_ev === 1'b1);
         ms += int'(merge_ev === 1'b1);
         for (int s = 0; s < SLOTS; s++) begin
            if (rs_out[s].valid === 1'b1) begin
               got[s] = rs_out[s];
               at[s] = i;
            end
         end
         if (rs_out[0].valid === 1'b1) begin
            rob0 = rob_rd;
         end
      end
      for (i = 0; i < SLOTS; i++) begin
         `CHK(got[i].tag, g[i].valid ? g[i].tag : 6'h00)
      end
   endtask : run

   // Four ports wanted at once: third slot waits one cycle
   task automatic t_ports();
      uop_t [SLOTS-1:0] g;
      logic [COUNT_W-1:0] c0;
      c0 = stall_cnt;
      g[0] = rd(6'h01, 5'h11, 5'h12, W_DWORD);
      g[1] = rd(6'h02, 5'h11, 5'h13, W_DWORD);
      g[2] = rd(6'h03, 5'h14, 5'h00, W_DWORD);
      g[3] = rd(6'h04, 5'h15, 5'h00, W_DWORD);
      run(g);
      `CHK(ps, 1)
      `CHK(stall_cnt, c0 + 16'h0001)
      `CHK({at[1], at[2], at[3]}, {32'd0, 32'd1, 32'd1})
      `CHK(got[1].src[0].port, 2'h0)
      `CHK(got[1].src[1].port, 2'h2)
      `CHK(got[2].src[0].port, 2'h0)
      `CHK({got[0].src[0].from_rob, got[2].src[0].from_rob}, 2'b11)
      $display("test ports done");
   endtask : t_ports

   // Readers see a writer in flight until its own tag writes back
   task automatic t_flight();
      uop_t [SLOTS-1:0] g;
      g = '0;
      g[0] = wr(6'h05, 4'h6, W_DWORD, 1'b0);
      g[1] = rd(6'h06, 5'h16, 5'h00, W_DWORD);
      run(g);
      `CHK({got[1].src[0].from_rob, got[1].src[0].tag}, {1'b0, 6'h05})
      fe_u.wback(1, 4'h6, 6'h09);
      g[0] = rd(6'h07, 5'h16, 5'h00, W_DWORD);
      g[1] = '0;
      run(g);
      `CHK(got[0].src[0].from_rob, 1'b0)
      fe_u.wback(0, 4'h6, 6'h05);
      g[0] = rd(6'h08, 5'h16, 5'h00, W_DWORD);
      run(g);
      `CHK(got[0].src[0].from_rob, 1'b1)
      `CHK({rob0[0].valid, rob0[0].tag, rob0[1].valid}, {1'b1, 6'h05, 1'b0})
      $display("test flight done");
   endtask : t_flight

   // Latencies of two groups; expected slot s in nibble s
   task automatic lat(input uop_t [SLOTS-1:0] g, input logic [15:0] e);
      run(g);
      for (int s = 0; s < SLOTS; s++) begin
         `CHK(got[s].latency, e[4*s+:3])
      end
   endtask : lat

   task automatic t_latency();
      uop_t [SLOTS-1:0] g;
      g[0] = mk(OP_PACKED_SINGLE_ADD, DOM_VEC_FP, 4'h7, W_DWORD, 1'b0, 6'h0A, 0, 0, W_DWORD);
      g[1] = mk(OP_PACKED_INTEGER_AND, DOM_VEC_INT, 4'h8, W_DWORD, 1'b0, 6'h0B, 5'h17, 0, W_DWORD);
      g[2] = mk(OP_PACKED_SINGLE_ADD, DOM_VEC_FP, 4'hD, W_DWORD, 1'b0, 6'h0C, 5'h18, 0, W_DWORD);
      g[3] = mk(OP_FP_LOAD, DOM_X87, 4'hE, W_DWORD, 1'b0, 6'h0D, 0, 0, W_DWORD);
      lat(g, 16'h4423);
      g[0] = mk(OP_INT_LOAD, DOM_GPR, 4'h0, W_DWORD, 1'b0, 6'h0E, 0, 0, W_DWORD);
      g[1] = mk(OP_OTHER, DOM_X87, 4'h0, W_DWORD, 1'b0, 6'h0F, 5'h17, 0, W_DWORD);
      g[2] = mk(OP_PACKED_INTEGER_AND, DOM_VEC_INT, 4'h0, W_DWORD, 1'b0, 6'h10, 5'h18, 0, W_DWORD);
      g[3] = rd(6'h11, 5'h17, 5'h00, W_DWORD);
      lat(g, 16'h1123);
      $display("test latency done");
   endtask : t_latency

   // Partial writes, folds, zero-extending and full writes
   task automatic t_partial();
      uop_t [SLOTS-1:0] g;
      g[0] = wr(6'h14, 4'h9, W_BYTE_LO, 1'b0);
      g[1] = wr(6'h15, 4'h9, W_BYTE_HI, 1'b0);
      g[2] = wr(6'h16, 4'hA, W_BYTE_LO, 1'b1);
      g[3] = wr(6'h17, 4'hB, W_WORD, 1'b0);
      run(g);
      `CHK(got[0].src[2].used, 1'b1)
      `CHK({got[1].src[2].from_rob, got[1].src[2].tag}, {1'b0, 6'h14})
      `CHK({got[2].src[2].used, ms}, {1'b0, 32'd0})
      g[0] = rd(6'h18, 5'h19, 5'h00, W_WORD);
      g[1] = rd(6'h19, 5'h1A, 5'h00, W_DWORD);
      g[2] = rd(6'h1A, 5'h1B, 5'h00, W_DWORD);
      g[3] = rd(6'h1B, 5'h19, 5'h00, W_WORD);
      run(g);
      `CHK(ms, 2)
      `CHK({at[0], at[1], at[2], at[3]}, {32'd1, 32'd1, 32'd2, 32'd2})
      mode64 = 1'b0;
      g[0] = wr(6'h1C, 4'hC, W_BYTE_LO, 1'b0);
      g[1] = wr(6'h1D, 4'hC, W_DWORD, 1'b0);
      g[2] = rd(6'h1E, 5'h1C, 5'h00, W_QWORD);
      g[3] = wr(6'h1F, 4'h5, W_QWORD, 1'b0);
      run(g);
      `CHK({ms, got[1].src[2].used}, {32'd0, 1'b0})
      `CHK(got[3].src[2].used, 1'b0)
      mode64 = 1'b1;
      $display("test partial done");
   endtask : t_partial

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : print_verdict

   initial begin
      mode64 = 1'b1;
      rst = 1'b1;
      repeat (8) @(posedge clock);
      @(negedge clock);
      rst = 1'b0;
      `CHK({group_ready, stall_cnt}, {1'b1, 16'h0000})
      t_ports();
      t_flight();
      t_latency();
      t_partial();
      print_verdict();
   end
endmodule : tb_top

bind rename_stall_hazard_logic rename_hazard_checker chk_u (.clock, .rst, .group_valid, .group,
   .group_ready, .rs_out, .rob_rd, .read_port_stall_event, .merge_stall_event,
   .read_port_stall_count);
